// ---- verilog/rtc_time_alarm.sv ----
// Time-of-day counter with alarm repeat logic and register port
//
// Our own choices: strobed register access and the placing of the registers.
`timescale 1ns/100ps
module rtc_time_alarm
  import rtc_pkg::*;
#(
  parameter int TICK_COUNT = TICK_CYCLES
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic por_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [31:0] rdata,
  output logic irq,
  output logic alarm_pulse,
  output logic second_pulse
);
  logic rst_n;
  logic on_r, wren_r;
  logic alarm_en_r, roll_r;
  logic [7:0] cnt_r;
  logic [31:0] alm_time_r;
  logic [31:0] rdata_r;
  logic [INT_W-1:0] stat_r, mask_r, stat_set;
  logic irq_r, alarm_pulse_r, tick_r, tick_d_r;
  logic [31:0] tick_cnt_r;
  logic wr_ctrl, wr_alarm, wr_time, wr_alm_time, wr_stat, wr_mask, ld_time;
  logic alarm_hit, alarm_done;
  logic [31:0] time_word;
  time_s cur, ldv;
  logic c_s0, c_s1, c_m0, c_m1, c_h0;
  logic [3:0] hours_units_digit_wrap;

  // Power-on also clears everything that the ordinary reset clears
  assign rst_n = reset_n & por_n;

  assign wr_ctrl = wr_stb && (addr == CTRL_OFS);
  assign wr_alarm = wr_stb && (addr == ALARM_OFS);
  assign wr_time = wr_stb && (addr == TIME_OFS);
  assign wr_alm_time = wr_stb && (addr == ALM_TIME_OFS);
  assign wr_stat = wr_stb && (addr == INT_STAT_OFS);
  assign wr_mask = wr_stb && (addr == INT_MASK_OFS);
  assign ld_time = wr_time && wren_r;

  // Field placement of the time word
  assign ldv.hours_tens_digit = wdata[HOURS_TENS_DIGIT_LSB +: 2];
  assign ldv.hours_units_digit = wdata[HOURS_UNITS_DIGIT_LSB +: 4];
  assign ldv.minutes_tens_digit = wdata[MINUTES_TENS_DIGIT_LSB +: 3];
  assign ldv.minutes_units_digit = wdata[MINUTES_UNITS_DIGIT_LSB +: 4];
  assign ldv.seconds_tens_digit = wdata[SECONDS_TENS_DIGIT_LSB +: 3];
  assign ldv.seconds_units_digit = wdata[SECONDS_UNITS_DIGIT_LSB +: 4];

  always_comb begin
    time_word = '0;
    time_word[HOURS_TENS_DIGIT_LSB +: 2] = cur.hours_tens_digit;
    time_word[HOURS_UNITS_DIGIT_LSB +: 4] = cur.hours_units_digit;
    time_word[MINUTES_TENS_DIGIT_LSB +: 3] = cur.minutes_tens_digit;
    time_word[MINUTES_UNITS_DIGIT_LSB +: 4] = cur.minutes_units_digit;
    time_word[SECONDS_TENS_DIGIT_LSB +: 3] = cur.seconds_tens_digit;
    time_word[SECONDS_UNITS_DIGIT_LSB +: 4] = cur.seconds_units_digit;
  end

  // Clock control
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      on_r <= 1'b0;
      wren_r <= 1'b0;
    end else if (wr_ctrl) begin
      on_r <= wdata[CTRL_ON_BIT];
      wren_r <= wdata[CTRL_WREN_BIT];
    end
  end

  // One-second timebase, cleared to zero while the clock is off
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_r <= '0;
      tick_r <= 1'b0;
      tick_d_r <= 1'b0;
    end else begin
      tick_d_r <= tick_r && !ld_time;
      if (!on_r) begin
        tick_cnt_r <= '0;
        tick_r <= 1'b0;
      end else if (tick_cnt_r == 32'(TICK_COUNT - 1)) begin
        tick_cnt_r <= '0;
        tick_r <= 1'b1;
      end else begin
        tick_cnt_r <= tick_cnt_r + 32'h1;
        tick_r <= 1'b0;
      end
    end
  end

  // BCD chain; a software load wins over a tick in the same cycle
  assign hours_units_digit_wrap = (cur.hours_tens_digit == HOURS_TENS_DIGIT_MAX) ? HOURS_UNITS_DIGIT_MAX_AT_20 : UNITS_MAX;

  bcd_digit #(.W(4)) seconds_units_digit_u (
    .ref_clk(ref_clk), .rst_n(rst_n), .inc(tick_r && !ld_time), .wrap_at(UNITS_MAX),
    .ld(ld_time), .ld_val(ldv.seconds_units_digit), .q(cur.seconds_units_digit), .carry(c_s0)
  );
  bcd_digit #(.W(3)) seconds_tens_digit_u (
    .ref_clk(ref_clk), .rst_n(rst_n), .inc(c_s0), .wrap_at(TENS_MAX_MS),
    .ld(ld_time), .ld_val(ldv.seconds_tens_digit), .q(cur.seconds_tens_digit), .carry(c_s1)
  );
  bcd_digit #(.W(4)) minutes_units_digit_u (
    .ref_clk(ref_clk), .rst_n(rst_n), .inc(c_s1), .wrap_at(UNITS_MAX),
    .ld(ld_time), .ld_val(ldv.minutes_units_digit), .q(cur.minutes_units_digit), .carry(c_m0)
  );
  bcd_digit #(.W(3)) minutes_tens_digit_u (
    .ref_clk(ref_clk), .rst_n(rst_n), .inc(c_m0), .wrap_at(TENS_MAX_MS),
    .ld(ld_time), .ld_val(ldv.minutes_tens_digit), .q(cur.minutes_tens_digit), .carry(c_m1)
  );
  bcd_digit #(.W(4)) hours_units_digit_u (
    .ref_clk(ref_clk), .rst_n(rst_n), .inc(c_m1), .wrap_at(hours_units_digit_wrap),
    .ld(ld_time), .ld_val(ldv.hours_units_digit), .q(cur.hours_units_digit), .carry(c_h0)
  );
  bcd_digit #(.W(2)) hours_tens_digit_u (
    .ref_clk(ref_clk), .rst_n(rst_n), .inc(c_h0), .wrap_at(HOURS_TENS_DIGIT_MAX),
    .ld(ld_time), .ld_val(ldv.hours_tens_digit), .q(cur.hours_tens_digit), .carry()
  );

  // Alarm fires on the cycle after a tick when the new time matches
  assign alarm_hit = tick_d_r && alarm_en_r && (time_word == (alm_time_r & TIME_MASK));
  assign alarm_done = alarm_hit && !wr_alarm && (cnt_r == 8'h00) && !roll_r;

  // Alarm control survives an ordinary reset, only power-on clears it
  always_ff @(posedge ref_clk or negedge por_n) begin
    if (!por_n) begin
      alarm_en_r <= 1'b0;
      roll_r <= 1'b0;
      cnt_r <= ALM_CNT_RESET;
      alm_time_r <= '0;
    end else begin
      if (wr_alm_time) begin
        alm_time_r <= wdata & TIME_MASK;
      end
      if (wr_alarm) begin
        alarm_en_r <= wdata[ALM_EN_BIT];
        roll_r <= wdata[ALM_ROLL_BIT];
        cnt_r <= wdata[ALM_CNT_LSB +: 8];
      end else if (alarm_hit) begin
        if (cnt_r != 8'h00) begin
          cnt_r <= cnt_r - 8'h01;
        end else if (roll_r) begin
          cnt_r <= ALM_CNT_ALL_ONES;
        end else begin
          alarm_en_r <= 1'b0;
        end
      end
    end
  end

  // Sticky status: a new event wins over a write-one-to-clear
  assign stat_set = {alarm_done, alarm_hit, tick_r};

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      stat_r <= '0;
      mask_r <= '0;
      irq_r <= 1'b0;
      alarm_pulse_r <= 1'b0;
    end else begin
      if (wr_stat) begin
        stat_r <= (stat_r & ~wdata[INT_W-1:0]) | stat_set;
      end else begin
        stat_r <= stat_r | stat_set;
      end
      if (wr_mask) begin
        mask_r <= wdata[INT_W-1:0];
      end
      irq_r <= |(stat_r & mask_r);
      alarm_pulse_r <= alarm_hit;
    end
  end

  // Read port: data stand only in the cycle after the strobe
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= '0;
    end else if (!rd_stb) begin
      rdata_r <= '0;
    end else if (addr == CTRL_OFS) begin
      rdata_r <= 32'(on_r) << CTRL_ON_BIT | 32'(wren_r) << CTRL_WREN_BIT;
    end else if (addr == ALARM_OFS) begin
      rdata_r <= 32'(alarm_en_r) << ALM_EN_BIT | 32'(roll_r) << ALM_ROLL_BIT
        | 32'(on_r && alarm_en_r) << ALM_SYNC_BIT | 32'(cnt_r);
    end else if (addr == TIME_OFS) begin
      rdata_r <= time_word;
    end else if (addr == ALM_TIME_OFS) begin
      rdata_r <= alm_time_r;
    end else if (addr == INT_STAT_OFS) begin
      rdata_r <= 32'(stat_r);
    end else if (addr == INT_MASK_OFS) begin
      rdata_r <= 32'(mask_r);
    end else begin
      rdata_r <= '0;
    end
  end

  assign rdata = rdata_r;
  assign irq = irq_r;
  assign alarm_pulse = alarm_pulse_r;
  assign second_pulse = tick_d_r;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence alarm_at_zero_s;
    alarm_hit && !wr_alarm && (cnt_r == 8'h00);
  endsequence

  // One second taken by the counter chain
  sequence tick_taken_s;
    tick_r && !ld_time;
  endsequence

  // Tick taken with seconds at 59, so this tick carries into the minutes
  sequence carry_to_min_s;
    tick_taken_s ##0 (time_word[15:8] == 8'h59);
  endsequence

  // Cycles since the last tick; the first second after switch-on is one cycle longer
  logic [31:0] gap_cnt_r;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      gap_cnt_r <= '0;
    end else if (tick_r || !on_r) begin
      gap_cnt_r <= '0;
    end else begin
      gap_cnt_r <= gap_cnt_r + 32'h1;
    end
  end

  count_dec_a: assert property (alarm_hit && !wr_alarm && cnt_r != 8'h00 |=>
    cnt_r == $past(cnt_r) - 8'h01 && alarm_en_r) else $error("repeat count not decremented");
  count_roll_a: assert property (alarm_at_zero_s ##0 roll_r |=>
    cnt_r == 8'hff && alarm_en_r) else $error("repeat count did not roll over");
  alarm_stop_a: assert property (alarm_at_zero_s ##0 !roll_r |=>
    !alarm_en_r && cnt_r == 8'h00) else $error("alarm enable not cleared");
  time_guard_a: assert property (wr_time && !wren_r && !tick_r |=>
    time_word == $past(time_word)) else $error("time written without enable");
  time_load_a: assert property (wr_time && wren_r |=>
    time_word == ($past(wdata) & TIME_MASK)) else $error("time write not stored");
  time_rsvd_a: assert property (rd_stb && addr == TIME_OFS |=>
    (rdata & ~TIME_MASK) == 32'h0) else $error("reserved time bits read nonzero");
  midnight_wrap_a: assert property (tick_taken_s ##0 time_word == 32'h23595900 |=>
    time_word == 32'h0) else $error("time did not wrap at midnight");
  sec_step_a: assert property (tick_r && !ld_time && cur.seconds_units_digit < 4'h9 |=>
    cur.seconds_units_digit == $past(cur.seconds_units_digit) + 4'h1) else $error("seconds did not advance");
  irq_follow_a: assert property (##1 irq == |($past(stat_r) & $past(mask_r)))
    else $error("interrupt does not follow status");
  cnt_write_a: assert property (wr_alarm |=>
    cnt_r == $past(wdata[ALM_CNT_LSB +: 8]))
    else $error("repeat count write not stored");
  alarm_pulse_a: assert property (alarm_hit |=>
    alarm_pulse)
    else $error("alarm event not signalled");
  event_flag_a: assert property (alarm_hit |=>
    stat_r[INT_ALM_BIT])
    else $error("alarm status not set");
  done_flag_a: assert property (alarm_done |=>
    stat_r[INT_DONE_BIT] && !alarm_en_r)
    else $error("exhausted alarm not flagged");
  count_hold_a: assert property (!wr_alarm && !alarm_hit |=>
    $stable(cnt_r))
    else $error("repeat count moved without an event");
  enable_hold_a: assert property (!wr_alarm && !alarm_done |=>
    $stable(alarm_en_r))
    else $error("alarm enable moved without cause");
  sync_read_a: assert property (rd_stb && addr == ALARM_OFS |=>
    rdata[ALM_SYNC_BIT] == $past(on_r && alarm_en_r))
    else $error("alarm sync status read wrong");
  second_out_a: assert property (tick_taken_s |=>
    second_pulse)
    else $error("second pulse missing");
  min_step_a: assert property (carry_to_min_s ##0 cur.minutes_units_digit < UNITS_MAX |=>
    cur.minutes_units_digit == $past(cur.minutes_units_digit) + 4'h1 && time_word[15:8] == 8'h00)
    else $error("minutes did not take the carry");
  hour_step_a: assert property (tick_taken_s ##0 time_word == 32'h19595900 |=>
    time_word == 32'h20000000)
    else $error("hours did not carry into tens");
  time_idle_a: assert property (!tick_r && !ld_time |=>
    $stable(time_word))
    else $error("time changed without tick or load");
  hours_map_a: assert property (ld_time |=>
    cur.hours_tens_digit == $past(wdata[29:28]) && cur.hours_units_digit == $past(wdata[27:24]))
    else $error("hours field misplaced");
  minutes_map_a: assert property (ld_time |=>
    cur.minutes_tens_digit == $past(wdata[22:20]) && cur.minutes_units_digit == $past(wdata[19:16]))
    else $error("minutes field misplaced");
  seconds_map_a: assert property (ld_time |=>
    cur.seconds_tens_digit == $past(wdata[14:12]) && cur.seconds_units_digit == $past(wdata[11:8]))
    else $error("seconds field misplaced");
  rdata_idle_a: assert property (!rd_stb |=>
    rdata == 32'h0)
    else $error("read data outside the read cycle");
  tick_gap_a: assert property (on_r |->
    gap_cnt_r <= 32'(TICK_COUNT))
    else $error("second tick overdue");
endmodule // rtc_time_alarm

// ---- include/rtc_pkg.sv ----
// Register map, field layout and timing constants of the time-of-day and alarm block
package rtc_pkg;
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] ALARM_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] TIME_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] ALM_TIME_OFS = 8'h0c;
  localparam logic [ADDR_W-1:0] INT_STAT_OFS = 8'h10;
  localparam logic [ADDR_W-1:0] INT_MASK_OFS = 8'h14;
  // Clock control fields
  localparam int CTRL_ON_BIT = 15;
  localparam int CTRL_WREN_BIT = 3;
  // Alarm control fields
  localparam int ALM_EN_BIT = 15;
  localparam int ALM_ROLL_BIT = 14;
  localparam int ALM_SYNC_BIT = 12;
  localparam int ALM_CNT_LSB = 0;
  localparam logic [7:0] ALM_CNT_RESET = 8'h00;
  localparam logic [7:0] ALM_CNT_ALL_ONES = 8'hff;
  // Time value fields
  localparam int HOURS_TENS_DIGIT_LSB = 28;
  localparam int HOURS_UNITS_DIGIT_LSB = 24;
  localparam int MINUTES_TENS_DIGIT_LSB = 20;
  localparam int MINUTES_UNITS_DIGIT_LSB = 16;
  localparam int SECONDS_TENS_DIGIT_LSB = 12;
  localparam int SECONDS_UNITS_DIGIT_LSB = 8;
  localparam logic [31:0] TIME_MASK = 32'h3f7f7f00;
  localparam logic [3:0] UNITS_MAX = 4'h9;
  localparam logic [3:0] HOURS_UNITS_DIGIT_MAX_AT_20 = 4'h3;
  localparam logic [2:0] TENS_MAX_MS = 3'h5;
  localparam logic [1:0] HOURS_TENS_DIGIT_MAX = 2'h2;
  // Interrupt status bits
  localparam int INT_SEC_BIT = 0;
  localparam int INT_ALM_BIT = 1;
  localparam int INT_DONE_BIT = 2;
  localparam int INT_W = 3;
  // Timing
  localparam longint SECOND_NS = 1000000000;
  localparam longint CLK_PERIOD_NS = 100;
  localparam int TICK_CYCLES = int'(SECOND_NS / CLK_PERIOD_NS);

  typedef struct packed {
    logic [1:0] hours_tens_digit;
    logic [3:0] hours_units_digit;
    logic [2:0] minutes_tens_digit;
    logic [3:0] minutes_units_digit;
    logic [2:0] seconds_tens_digit;
    logic [3:0] seconds_units_digit;
  } time_s;
endpackage

// ---- verilog/bcd_digit.sv ----
// One BCD digit of the time counter with load and carry
`timescale 1ns/100ps
module bcd_digit #(
  parameter int W = 4
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic inc,
  input wire logic [W-1:0] wrap_at,
  input wire logic ld,
  input wire logic [W-1:0] ld_val,
  output logic [W-1:0] q,
  output logic carry
);
  logic [W-1:0] q_r;

  // Wrap also on out-of-range values so a bad load cannot run away
  assign carry = inc && (q_r >= wrap_at);
  assign q = q_r;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      q_r <= '0;
    end else if (ld) begin
      q_r <= ld_val;
    end else if (carry) begin
      q_r <= '0;
    end else if (inc) begin
      q_r <= W'(q_r + 1'b1);
    end
  end
endmodule // bcd_digit

// ---- verif/rtc_time_alarm_tb.sv ----
// Self-checking bench for the time-of-day and alarm block
`timescale 1ns/100ps
module rtc_time_alarm_tb;
  import rtc_pkg::*;
  // Short second so each carry and alarm round fits in a short run
  localparam int TICK = 8;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic por_n = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [31:0] wdata = '0;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic [31:0] rdata;
  logic irq;
  logic alarm_pulse;
  logic second_pulse;
  int n_mismatch = 0;
  int checks_done = 0;
  logic [31:0] v;
  logic got;
  logic [31:0] t_in [3] = '{32'h23595900, 32'h19595900, 32'h12345900};
  logic [31:0] t_out [3] = '{32'h00000000, 32'h20000000, 32'h12350000};

  always #50 ref_clk = ~ref_clk;

  rtc_time_alarm #(.TICK_COUNT(TICK)) u_rtc_time_alarm (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .por_n(por_n),
    .addr(addr),
    .wdata(wdata),
    .wr_stb(wr_stb),
    .rd_stb(rd_stb),
    .rdata(rdata),
    .irq(irq),
    .alarm_pulse(alarm_pulse),
    .second_pulse(second_pulse)
  );

  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge ref_clk);
    wr_stb <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge ref_clk);
    rd_stb <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic wait_ev(input logic want_sec, input logic must, output logic seen);
    seen = 1'b0;
    for (int i = 0; i < 5 * TICK; i++) begin
      @(posedge ref_clk);
      #1;
      if ((want_sec ? second_pulse : alarm_pulse) === 1'b1) begin
        seen = 1'b1;
        break;
      end
    end
    if (must && !seen) begin
      n_mismatch++;
      $display("Error at %0t: expected pulse never came", $time);
      tally_and_finish();
    end
  endtask

  // Reload midnight so the next second matches the alarm time again
  task automatic alarm_round(input logic ev, input logic [31:0] exp_alm,
                             input logic [1:0] exp_st);
    wr(TIME_OFS, 32'h00000000);
    wr(CTRL_OFS, 32'h00008008);
    wait_ev(1'b0, ev, got);
    chk(got, ev);
    rd(ALARM_OFS, v);
    chk(v, exp_alm);
    rd(INT_STAT_OFS, v);
    chk(v[INT_DONE_BIT:INT_ALM_BIT], exp_st);
    chk(irq, exp_st[0]);
    wr(INT_STAT_OFS, 32'h00000007);
    repeat (2) @(posedge ref_clk);
    #1;
    chk(irq, 1'b0);
  endtask

  initial begin
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'b1;
    por_n <= 1'b1;
    rd(TIME_OFS, v);
    chk(v, 32'h00000000);
    rd(ALARM_OFS, v);
    chk(v, 32'h00000000);
    rd(8'h20, v);
    chk(v, 32'h00000000);
    $display("Test reset_values done");
    wr(TIME_OFS, 32'h12345600);
    rd(TIME_OFS, v);
    chk(v, 32'h00000000);
    wr(CTRL_OFS, 32'h00000008);
    wr(TIME_OFS, 32'hffffffff);
    rd(TIME_OFS, v);
    chk(v, 32'h3f7f7f00);
    wr(TIME_OFS, 32'h12345600);
    rd(TIME_OFS, v);
    chk(v, 32'h12345600);
    $display("Test time_write done");
    for (int i = 0; i < 3; i++) begin
      wr(CTRL_OFS, 32'h00000008);
      wr(TIME_OFS, t_in[i]);
      wr(CTRL_OFS, 32'h00008008);
      wait_ev(1'b1, 1'b1, got);
      rd(TIME_OFS, v);
      chk(v, t_out[i]);
    end
    $display("Test time_carry done");
    // Clock off before touching the repeat count
    wr(CTRL_OFS, 32'h00000008);
    wr(INT_MASK_OFS, 32'h00000002);
    wr(ALM_TIME_OFS, 32'h00000100);
    wr(ALARM_OFS, 32'h00008001);
    rd(ALARM_OFS, v);
    chk(v, 32'h00008001);
    alarm_round(1'b1, 32'h00009000, 2'b01);
    alarm_round(1'b1, 32'h00000000, 2'b11);
    alarm_round(1'b0, 32'h00000000, 2'b00);
    wr(CTRL_OFS, 32'h00000008);
    wr(ALARM_OFS, 32'h0000c000);
    alarm_round(1'b1, 32'h0000d0ff, 2'b01);
    $display("Test alarm_repeat done");
    @(posedge ref_clk);
    reset_n <= 1'b0;
    @(posedge ref_clk);
    reset_n <= 1'b1;
    rd(ALARM_OFS, v);
    chk(v, 32'h0000c0ff);
    rd(ALM_TIME_OFS, v);
    chk(v, 32'h00000100);
    rd(TIME_OFS, v);
    chk(v, 32'h00000000);
    $display("Test soft_reset done");
    @(posedge ref_clk);
    por_n <= 1'b0;
    @(posedge ref_clk);
    por_n <= 1'b1;
    rd(ALARM_OFS, v);
    chk(v, 32'h00000000);
    rd(ALM_TIME_OFS, v);
    chk(v, 32'h00000000);
    $display("Test power_on_reset done");
    tally_and_finish();
  end
endmodule // rtc_time_alarm_tb
